/* File: sram_burst_pkg.sv */
package sram_burst_pkg;
  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int DATA_W   = 18;
  localparam int ADDR_W   = 19;
  localparam int LANES    = 2;
  localparam int LANE_W   = 9;
  localparam int WIDE_W   = 2 * DATA_W;
  localparam int WLANES   = 2 * LANES;
  localparam int DEPTH    = 1 << ADDR_W;
  // ------------------------------------------------------------
  // clock pin order in the edge bundle
  // ------------------------------------------------------------
  localparam int LINK_PINS = 4;
  localparam int PIN_K     = 0;
  localparam int PIN_KN    = 1;
  localparam int PIN_C     = 2;
  localparam int PIN_CN    = 3;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 100;
  localparam int DLL_STOP_NS      = 30;
  localparam int DLL_STOP_CYC     = (DLL_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINK_HALF_CYC    = 4;
  localparam int DLL_GAP_CYC      = LINK_HALF_CYC + DLL_STOP_CYC;
  localparam int CNT_W            = 11;
  localparam int GAP_W            = 4;
  localparam logic [CNT_W-1:0] LOCK_CYCLES = 11'h400;
  localparam logic [CNT_W-1:0] IMP_CYCLES  = 11'h400;
  localparam logic [GAP_W-1:0] GAP_LIMIT   = GAP_W'(DLL_GAP_CYC);
  localparam logic [1:0]       STRAP_SETTLE = 2'h3;
  // ------------------------------------------------------------
  // read output phases
  // ------------------------------------------------------------
  typedef enum logic [1:0] {OUT_IDLE, OUT_FIRST, OUT_SECOND} out_phase_t;
endpackage

/* File: link_edge_if.sv */
`timescale 1ns/1ps
interface link_edge_if;
  logic [sram_burst_pkg::LINK_PINS-1:0] level;
  logic [sram_burst_pkg::LINK_PINS-1:0] rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

/* File: pin_edge_sync.sv */
`timescale 1ns/1ps
module pin_edge_sync (
  // clock and reset
  input  wire logic                                 clock,
  input  wire logic                                 reset_n,
  // raw pins
  input  wire logic [sram_burst_pkg::LINK_PINS-1:0] pins,
  // synchronised levels and rising edges
  link_edge_if.src                                  edges
);
  logic [sram_burst_pkg::LINK_PINS-1:0] meta;
  logic [sram_burst_pkg::LINK_PINS-1:0] stable;
  logic [sram_burst_pkg::LINK_PINS-1:0] last;

  always_ff @(posedge clock or negedge reset_n) begin
    // all ones: a pin idling low or high shows no false rise after reset
    if (!reset_n) begin
      meta   <= '1;
      stable <= '1;
      last   <= '1;
    end else begin
      meta   <= pins;
      stable <= meta;
      last   <= stable;
    end
  end

  assign edges.level = stable;
  assign edges.rise  = stable & ~last;
endmodule

/* File: burst_sram_device.sv */
// What this block does
// - read select low at positive input clock rise starts read, latches read address
// - first read word at negative output clock rise t+1, second at positive rise t+2
// - every access is two sequential words, latched address word first
// - outputs go high impedance after next output clock rise following a burst
// - write select low at positive input clock rise latches lower write word
// - next negative input clock rise latches write address and upper write word
// - both halves then committed to the array at the write address
// - byte-lane selects sampled per word; deasserted lanes keep stored contents
// - selects and byte-lane selects captured at input clock pair rises
// - port selects sampled only at positive input rise; ports independent
// - pending reads and writes complete before a deselected port goes idle
// - read and write may start in the same cycle at any addresses
// - reads return newest data, forwarding a just-issued write
// - single-clock mode times outputs from the input clock pair
// - free-running echo clocks follow output clocks, or input clocks in single mode
// - output impedance re-adjusted every 1024 input clock cycles
// - with DLL enabled, lock declared after 1024 stable input clock cycles
// - input clock stopped or slowed so that no input clock pair rise comes for 5 system clock cycles resets the DLL
// - powers up with both ports idle and outputs high impedance
// - byte selects may change between halves; select zero covers bits 8..0
`timescale 1ns/1ps
module burst_sram_device (
  // clock and reset
  input  wire logic                                  clock,
  input  wire logic                                  reset_n,
  // link clocks
  input  wire logic                                  inClockPos,
  input  wire logic                                  inClockNeg,
  input  wire logic                                  outClockPos,
  input  wire logic                                  outClockNeg,
  // host controls
  input  wire logic                                  read_select_n,
  input  wire logic                                  write_select_n,
  input  wire logic [sram_burst_pkg::LANES-1:0]      byte_lane_write_select_n,
  input  wire logic [sram_burst_pkg::ADDR_W-1:0]     address,
  input  wire logic [sram_burst_pkg::DATA_W-1:0]     writeData,
  input  wire logic                                  dll_disable_n,
  // read port
  output logic      [sram_burst_pkg::DATA_W-1:0]     readData,
  output logic                                       readDataOe,
  // echo clocks and status
  output logic                                       echo_strobe_pos,
  output logic                                       echo_strobe_neg,
  output logic                                       dllLocked,
  output logic                                       impedanceUpdate
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int BUS_W = 2 + sram_burst_pkg::LANES + sram_burst_pkg::ADDR_W
                         + sram_burst_pkg::DATA_W + 1;

  link_edge_if linkEdges ();

  pin_edge_sync u_clock_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .pins    ({outClockNeg, outClockPos, inClockNeg, inClockPos}),
    .edges   (linkEdges)
  );

  logic [BUS_W-1:0] busMeta;
  logic [BUS_W-1:0] busStable;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busMeta   <= '1;
      busStable <= '1;
    end else begin
      busMeta   <= {read_select_n, write_select_n, byte_lane_write_select_n,
                    address, writeData, dll_disable_n};
      busStable <= busMeta;
    end
  end

  wire                                    rpsS;
  wire                                    wpsS;
  wire [sram_burst_pkg::LANES-1:0]        bwsS;
  wire [sram_burst_pkg::ADDR_W-1:0]       addrS;
  wire [sram_burst_pkg::DATA_W-1:0]       dataS;
  wire                                    dllEnS;
  assign {rpsS, wpsS, bwsS, addrS, dataS, dllEnS} = busStable;

  // ------------------------------------------------------------
  // strap and clock selection
  // ------------------------------------------------------------
  logic       singleClock;
  logic [1:0] strapWait;
  wire        strapNow = (strapWait == sram_burst_pkg::STRAP_SETTLE - 2'h1);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strapWait   <= 2'h0;
      singleClock <= 1'b0;
    end else if (strapWait != sram_burst_pkg::STRAP_SETTLE) begin
      strapWait <= strapWait + 2'h1;
      if (strapNow) begin
        singleClock <= linkEdges.level[sram_burst_pkg::PIN_C]
                     & linkEdges.level[sram_burst_pkg::PIN_CN];
      end
    end
  end

  wire kRise  = linkEdges.rise[sram_burst_pkg::PIN_K];
  wire knRise = linkEdges.rise[sram_burst_pkg::PIN_KN];
  wire outPosRise = singleClock ? kRise  : linkEdges.rise[sram_burst_pkg::PIN_C];
  wire outNegRise = singleClock ? knRise : linkEdges.rise[sram_burst_pkg::PIN_CN];
  wire echoPos = singleClock ? linkEdges.level[sram_burst_pkg::PIN_K]
                             : linkEdges.level[sram_burst_pkg::PIN_C];
  wire echoNeg = singleClock ? linkEdges.level[sram_burst_pkg::PIN_KN]
                             : linkEdges.level[sram_burst_pkg::PIN_CN];

  // ------------------------------------------------------------
  // memory array and write path
  // ------------------------------------------------------------
  logic [sram_burst_pkg::WIDE_W-1:0] mem [sram_burst_pkg::DEPTH];

  logic                               wrActive;
  logic [sram_burst_pkg::DATA_W-1:0]  wrLowData;
  logic [sram_burst_pkg::LANES-1:0]   wrLowMask;
  logic                               commitValid;
  logic                               commitPulse;
  logic [sram_burst_pkg::ADDR_W-1:0]  commitAddr;
  logic [sram_burst_pkg::WIDE_W-1:0]  commitData;
  logic [sram_burst_pkg::WLANES-1:0]  commitMask;

  // lower half on positive input rise, upper half and address on negative rise
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrActive  <= 1'b0;
      wrLowData <= '0;
      wrLowMask <= '0;
    end else if (kRise) begin
      wrActive  <= !wpsS;
      wrLowData <= dataS;
      wrLowMask <= ~bwsS;
    end else if (knRise) begin
      wrActive <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      commitValid <= 1'b0;
      commitPulse <= 1'b0;
      commitAddr  <= '0;
      commitData  <= '0;
      commitMask  <= '0;
    end else begin
      commitPulse <= knRise && wrActive;
      if (knRise && wrActive) begin
        commitValid <= 1'b1;
        commitAddr  <= addrS;
        commitData  <= {dataS, wrLowData};
        commitMask  <= {~bwsS, wrLowMask};
      end
    end
  end

  // self-timed commit, one cycle after the upper half lands
  always_ff @(posedge clock) begin
    if (commitPulse) begin
      for (int lane = 0; lane < sram_burst_pkg::WLANES; lane++) begin
        if (commitMask[lane]) begin
          mem[commitAddr][lane*sram_burst_pkg::LANE_W +: sram_burst_pkg::LANE_W] <=
            commitData[lane*sram_burst_pkg::LANE_W +: sram_burst_pkg::LANE_W];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // read request pipeline
  // ------------------------------------------------------------
  logic                               reqValid;
  logic [sram_burst_pkg::ADDR_W-1:0]  reqAddr;
  logic                               issueValid;
  logic [sram_burst_pkg::ADDR_W-1:0]  issueAddr;
  logic [sram_burst_pkg::ADDR_W-1:0]  burstAddr;
  sram_burst_pkg::out_phase_t         outPhase;

  // a request taken on the same cycle as an output rise waits one output cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reqValid   <= 1'b0;
      reqAddr    <= '0;
      issueValid <= 1'b0;
      issueAddr  <= '0;
    end else begin
      if (kRise) begin
        reqValid <= !rpsS;
        reqAddr  <= addrS;
      end else if (outPosRise) begin
        reqValid <= 1'b0;
      end
      if (outPosRise) begin
        issueValid <= reqValid;
        issueAddr  <= reqAddr;
      end else if (outNegRise) begin
        issueValid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // read data with write forwarding
  // ------------------------------------------------------------
  wire [sram_burst_pkg::ADDR_W-1:0] fetchAddr = outNegRise ? issueAddr : burstAddr;
  wire [sram_burst_pkg::WIDE_W-1:0] arrayWord = mem[fetchAddr];
  wire                              fwdHit    = commitValid && (commitAddr == fetchAddr);
  wire [sram_burst_pkg::WIDE_W-1:0] newestWord;

  for (genvar lane = 0; lane < sram_burst_pkg::WLANES; lane++) begin : g_fwd
    assign newestWord[lane*sram_burst_pkg::LANE_W +: sram_burst_pkg::LANE_W] =
      (fwdHit && commitMask[lane])
        ? commitData[lane*sram_burst_pkg::LANE_W +: sram_burst_pkg::LANE_W]
        : arrayWord[lane*sram_burst_pkg::LANE_W +: sram_burst_pkg::LANE_W];
  end

  wire [sram_burst_pkg::DATA_W-1:0] lowWord  = newestWord[sram_burst_pkg::DATA_W-1:0];
  wire [sram_burst_pkg::DATA_W-1:0] highWord =
    newestWord[sram_burst_pkg::WIDE_W-1:sram_burst_pkg::DATA_W];

  // ------------------------------------------------------------
  // read output sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      outPhase   <= sram_burst_pkg::OUT_IDLE;
      readData   <= '0;
      readDataOe <= 1'b0;
      burstAddr  <= '0;
    end else if (outNegRise) begin
      if (issueValid) begin
        outPhase   <= sram_burst_pkg::OUT_FIRST;
        readData   <= lowWord;
        readDataOe <= 1'b1;
        burstAddr  <= issueAddr;
      end else begin
        outPhase   <= sram_burst_pkg::OUT_IDLE;
        readDataOe <= 1'b0;
      end
    end else if (outPosRise) begin
      unique case (outPhase)
        sram_burst_pkg::OUT_FIRST: begin
          outPhase <= sram_burst_pkg::OUT_SECOND;
          readData <= highWord;
        end
        sram_burst_pkg::OUT_SECOND: begin
          outPhase   <= sram_burst_pkg::OUT_IDLE;
          readDataOe <= 1'b0;
        end
        sram_burst_pkg::OUT_IDLE: begin
          readDataOe <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // echo clocks, impedance update, DLL lock
  // ------------------------------------------------------------
  logic [sram_burst_pkg::CNT_W-1:0] impCount;
  logic [sram_burst_pkg::CNT_W-1:0] lockCount;
  logic [sram_burst_pkg::GAP_W-1:0] gapCount;
  wire clockStopped = (gapCount >= sram_burst_pkg::GAP_LIMIT);
  wire impWrap      = kRise && (impCount == sram_burst_pkg::IMP_CYCLES - 11'h001);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      echo_strobe_pos <= 1'b0;
      echo_strobe_neg <= 1'b0;
      impCount        <= '0;
      impedanceUpdate <= 1'b0;
    end else begin
      echo_strobe_pos <= echoPos;
      echo_strobe_neg <= echoNeg;
      impedanceUpdate <= impWrap;
      if (impWrap) begin
        impCount <= '0;
      end else if (kRise) begin
        impCount <= impCount + 11'h001;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gapCount  <= '0;
      lockCount <= '0;
      dllLocked <= 1'b0;
    end else begin
      if (kRise || knRise) begin
        gapCount <= '0;
      end else if (!clockStopped) begin
        gapCount <= gapCount + 4'h1;
      end
      if (clockStopped || !dllEnS) begin
        lockCount <= '0;
        dllLocked <= 1'b0;
      end else if (kRise && (lockCount != sram_burst_pkg::LOCK_CYCLES)) begin
        lockCount <= lockCount + 11'h001;
        dllLocked <= (lockCount == sram_burst_pkg::LOCK_CYCLES - 11'h001);
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_read_capture: assert property (@(posedge clock) disable iff (!reset_n)
    kRise && !rpsS |=> reqValid && (reqAddr == $past(addrS)))
    else $error("read request not captured");

  a_first_word: assert property (@(posedge clock) disable iff (!reset_n)
    outNegRise && issueValid |=> readDataOe && (readData == $past(lowWord))
                                 && (outPhase == sram_burst_pkg::OUT_FIRST))
    else $error("first read word not driven");

  a_second_word: assert property (@(posedge clock) disable iff (!reset_n)
    outPosRise && !outNegRise && (outPhase == sram_burst_pkg::OUT_FIRST)
    |=> readDataOe && (readData == $past(highWord)))
    else $error("second read word not driven");

  a_bus_release: assert property (@(posedge clock) disable iff (!reset_n)
    outNegRise && !issueValid |=> !readDataOe)
    else $error("read bus not released");

  a_write_low: assert property (@(posedge clock) disable iff (!reset_n)
    kRise && !wpsS |=> wrActive && (wrLowData == $past(dataS)) && (wrLowMask == ~$past(bwsS)))
    else $error("lower write word not latched");

  a_write_high: assert property (@(posedge clock) disable iff (!reset_n)
    knRise && wrActive |=> commitPulse && (commitAddr == $past(addrS))
                           && (commitData[35:18] == $past(dataS)))
    else $error("write address or upper word not latched");

  a_array_commit: assert property (@(posedge clock) disable iff (!reset_n)
    commitPulse && (commitMask == 4'hF) |=> mem[$past(commitAddr)] == $past(commitData))
    else $error("write not committed");

  a_imp_period: assert property (@(posedge clock) disable iff (!reset_n)
    impedanceUpdate |-> $past(impCount) == sram_burst_pkg::IMP_CYCLES - 11'h001)
    else $error("impedance update at wrong count");

  a_dll_lock: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(dllLocked) |-> $past(lockCount) == sram_burst_pkg::LOCK_CYCLES - 11'h001)
    else $error("DLL lock at wrong count");

  a_dll_reset: assert property (@(posedge clock) disable iff (!reset_n)
    clockStopped |=> !dllLocked && (lockCount == '0))
    else $error("DLL not reset on stopped clock");
endmodule

/* File: host_link_model.sv */
`timescale 1ns/1ps
module host_link_model (
  // system clock and link run control
  input  wire logic                                 clock,
  input  wire logic                                 run,
  input  wire logic                                 twoClock,
  // link pins toward the device
  output logic                                      inClockPos,
  output logic                                      inClockNeg,
  output logic                                      outClockPos,
  output logic                                      outClockNeg,
  output logic                                      read_select_n,
  output logic                                      write_select_n,
  output logic      [sram_burst_pkg::LANES-1:0]     byte_lane_write_select_n,
  output logic      [sram_burst_pkg::ADDR_W-1:0]    address,
  output logic      [sram_burst_pkg::DATA_W-1:0]    writeData,
  // read port and captured word slots
  input  wire logic [sram_burst_pkg::DATA_W-1:0]    readData,
  input  wire logic                                 readDataOe,
  output logic      [sram_burst_pkg::DATA_W-1:0]    cap0,
  output logic      [sram_burst_pkg::DATA_W-1:0]    cap1,
  output logic                                      capOe
);
  typedef logic [sram_burst_pkg::DATA_W-1:0] word_t;
  typedef logic [sram_burst_pkg::ADDR_W-1:0] addr_t;
  typedef logic [sram_burst_pkg::LANES-1:0]  lane_t;
  logic       [2:0] phase;
  wire logic  [2:0] nextPhase = phase + 3'h1;

  initial begin
    phase = 3'h7;
    inClockPos = 1'b0;
    inClockNeg = 1'b1;
    read_select_n = 1'b1;
    write_select_n = 1'b1;
    byte_lane_write_select_n = 2'h3;
    address = '0;
    writeData = '0;
  end

  // single-clock strap, or zero-skew output clocks; only changed under reset
  assign outClockPos = twoClock ? inClockPos : 1'b1;
  assign outClockNeg = twoClock ? inClockNeg : 1'b1;

  // ------------------------------------------------------------
  // link clock: 8 system cycles a period, frozen while stopped
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (run) begin
      phase <= nextPhase;
      inClockPos <= ~nextPhase[2];
      inClockNeg <= nextPhase[2];
    end
  end

  // word slots sampled mid-way between output edges
  always @(posedge clock) begin
    if (phase == 3'h1) begin
      cap0 <= readData;
      capOe <= readDataOe;
    end
    if (phase == 3'h5) begin
      cap1 <= readData;
    end
  end

  task automatic atPhase(input logic [2:0] p, output bit ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge clock);
      #1;
      ok = (phase == p);
    end
  endtask

  // one link period; idle lines show inverted data, never the last value
  task automatic burst(input logic rd, input logic wr, input addr_t ra, input addr_t wa,
                       input word_t d0, input word_t d1, input lane_t b0, input lane_t b1,
                       output bit ok);
    bit ok2;
    atPhase(3'h6, ok);
    read_select_n = ~rd;
    write_select_n = ~wr;
    address = rd ? ra : ~address;
    writeData = wr ? d0 : ~writeData;
    byte_lane_write_select_n = wr ? b0 : ~byte_lane_write_select_n;
    atPhase(3'h2, ok2);
    read_select_n = 1'b1;
    write_select_n = 1'b1;
    address = wr ? wa : ~address;
    writeData = wr ? d1 : ~writeData;
    byte_lane_write_select_n = wr ? b1 : ~byte_lane_write_select_n;
    ok = ok & ok2;
  endtask
endmodule

/* File: dual_port_burst_sram_interface_bench.sv */
`timescale 1ns/1ps
module dual_port_burst_sram_interface_bench;
  typedef logic [sram_burst_pkg::DATA_W-1:0] word_t;
  typedef logic [sram_burst_pkg::ADDR_W-1:0] addr_t;
  typedef logic [sram_burst_pkg::LANES-1:0]  lane_t;
  logic        clock;
  logic        reset_n;
  logic        run;
  logic        twoClock;
  logic        dll_disable_n;
  logic        inClockPos, inClockNeg, outClockPos, outClockNeg;
  logic        read_select_n, write_select_n;
  lane_t       byte_lane_write_select_n;
  addr_t       address;
  word_t       writeData, readData, cap0, cap1;
  logic        readDataOe, capOe, echo_strobe_pos, echo_strobe_neg;
  logic        dllLocked, impedanceUpdate;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          impPulses = 0;

  burst_sram_device i_dut (.clock(clock), .reset_n(reset_n), .inClockPos(inClockPos),
    .inClockNeg(inClockNeg), .outClockPos(outClockPos), .outClockNeg(outClockNeg),
    .read_select_n(read_select_n), .write_select_n(write_select_n),
    .byte_lane_write_select_n(byte_lane_write_select_n), .address(address),
    .writeData(writeData), .dll_disable_n(dll_disable_n), .readData(readData),
    .readDataOe(readDataOe), .echo_strobe_pos(echo_strobe_pos),
    .echo_strobe_neg(echo_strobe_neg), .dllLocked(dllLocked),
    .impedanceUpdate(impedanceUpdate));

  host_link_model i_host (.clock(clock), .run(run), .twoClock(twoClock),
    .inClockPos(inClockPos),
    .inClockNeg(inClockNeg), .outClockPos(outClockPos), .outClockNeg(outClockNeg),
    .read_select_n(read_select_n), .write_select_n(write_select_n),
    .byte_lane_write_select_n(byte_lane_write_select_n), .address(address),
    .writeData(writeData), .readData(readData), .readDataOe(readDataOe),
    .cap0(cap0), .cap1(cap1), .capOe(capOe));

  always #50 clock = ~clock;

  always @(posedge clock) begin
    if (impedanceUpdate === 1'b1) begin
      impPulses <= impPulses + 1;
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input word_t seen, input word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic lost(input bit ok);
    if (!ok) begin
      miscompares++;
      $display("[ERR] link phase wait expected reached seen timeout");
      give_verdict();
    end
  endtask

  task automatic waitPh(input logic [2:0] p, input int n);
    bit ok;
    repeat (n) begin
      i_host.atPhase(p, ok);
      lost(ok);
    end
  endtask

  task automatic bur(input logic rd, input logic wr, input addr_t ra, input addr_t wa,
                     input word_t d0, input word_t d1, input lane_t b0, input lane_t b1);
    bit ok;
    i_host.burst(rd, wr, ra, wa, d0, d1, b0, b1, ok);
    lost(ok);
  endtask

  task automatic expectRead(input word_t w0, input word_t w1);
    waitPh(3'h2, 1);
    check("read word0", cap0, w0);
    check("oe in burst", word_t'(capOe), 18'h00001);
    waitPh(3'h6, 1);
    check("read word1", cap1, w1);
  endtask

  task automatic readBack(input addr_t a, input word_t w0, input word_t w1);
    bur(1'b1, 1'b0, a, '0, '0, '0, 2'h3, 2'h3);
    bur(1'b0, 1'b0, '0, '0, '0, '0, 2'h3, 2'h3);
    expectRead(w0, w1);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic scnLock();
    check("oe at power-up", word_t'(readDataOe), 18'h00000);
    waitPh(3'h2, 1020);
    check("lock early", word_t'(dllLocked), 18'h00000);
    check("imp pulses early", word_t'(impPulses), 18'h00000);
    waitPh(3'h2, 6);
    check("lock after count", word_t'(dllLocked), 18'h00001);
    check("imp pulses", word_t'(impPulses), 18'h00001);
  endtask

  task automatic scnEcho();
    waitPh(3'h2, 1);
    check("echo pos low", word_t'(echo_strobe_pos), 18'h00000);
    check("echo neg high", word_t'(echo_strobe_neg), 18'h00001);
    waitPh(3'h6, 1);
    check("echo pos high", word_t'(echo_strobe_pos), 18'h00001);
    check("echo neg low", word_t'(echo_strobe_neg), 18'h00000);
  endtask

  task automatic scnWriteRead();
    bur(1'b0, 1'b1, '0, 19'h00010, 18'h12345, 18'h0ABCD, 2'h0, 2'h0);
    readBack(19'h00010, 18'h12345, 18'h0ABCD);
    waitPh(3'h2, 1);
    check("oe after burst", word_t'(capOe), 18'h00000);
    bur(1'b0, 1'b1, '0, 19'h00010, 18'h3FFFF, 18'h3FFFF, 2'h2, 2'h1);
    readBack(19'h00010, 18'h123FF, 18'h3FFCD);
  endtask

  task automatic scnConcurrent();
    bur(1'b0, 1'b1, '0, 19'h7FFFF, 18'h11111, 18'h22222, 2'h0, 2'h0);
    bur(1'b1, 1'b1, 19'h00010, 19'h7FFFF, 18'h0F0F0, 18'h30303, 2'h0, 2'h0);
    bur(1'b1, 1'b0, 19'h7FFFF, '0, '0, '0, 2'h3, 2'h3);
    expectRead(18'h123FF, 18'h3FFCD);
    expectRead(18'h0F0F0, 18'h30303);
  endtask

  task automatic scnStop();
    bur(1'b0, 1'b1, '0, 19'h00100, 18'h2A5A5, 18'h15A5A, 2'h0, 2'h0);
    run = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    check("lock after stop", word_t'(dllLocked), 18'h00000);
    check("oe while stopped", word_t'(readDataOe), 18'h00000);
    run = 1'b1;
    readBack(19'h00100, 18'h2A5A5, 18'h15A5A);
  endtask

  task automatic scnDisable();
    waitPh(3'h2, 1026);
    check("relock after stop", word_t'(dllLocked), 18'h00001);
    dll_disable_n = 1'b0;
    waitPh(3'h2, 2);
    check("lock when off", word_t'(dllLocked), 18'h00000);
    dll_disable_n = 1'b1;
    waitPh(3'h2, 1026);
    check("relock", word_t'(dllLocked), 18'h00001);
  endtask

  task automatic scnTwoClock();
    twoClock = 1'b1;
    reset_n = 1'b0;
    repeat (16) @(posedge clock);
    #1;
    reset_n = 1'b1;
    @(posedge clock);
    #1;
    check("oe after reset", word_t'(readDataOe), 18'h00000);
    check("lock after reset", word_t'(dllLocked), 18'h00000);
    readBack(19'h00100, 18'h2A5A5, 18'h15A5A);
    scnEcho();
  endtask

  initial begin
    clock = 1'b0;
    twoClock = 1'b0;
    reset_n = 1'b0;
    run = 1'b0;
    dll_disable_n = 1'b1;
    repeat (16) @(posedge clock);
    #1;
    reset_n = 1'b1;
    repeat (6) @(posedge clock);
    #1;
    run = 1'b1;
    scnLock();
    scnEcho();
    scnWriteRead();
    scnConcurrent();
    scnStop();
    scnDisable();
    scnTwoClock();
    give_verdict();
  end
endmodule
